// ===== rtl/dms_cfg.svh
/*
 Register indices, field positions and reset values for the DRAM
 maintenance register bank. Assumes inclusion by bare name from rtl/.
*/
`ifndef DMS_CFG_SVH
`define DMS_CFG_SVH

// ****************************************************************
// Register word indices (byte address = 4 * index)
// ****************************************************************
`define DMS_IDX_FAW 6'h28
`define DMS_IDX_GEOM 6'h2A
`define DMS_IDX_MODE_REQ 6'h2B
`define DMS_IDX_RFSH_REQ 6'h2C
`define DMS_IDX_ZQL_REQ 6'h2D
`define DMS_IDX_ZQS_REQ 6'h2E
`define DMS_IDX_SR_REQ 6'h2F
`define DMS_IDX_PS_REQ 6'h30
`define DMS_IDX_MODE_ACT 6'h31
`define DMS_IDX_RFSH_ACT 6'h32
`define DMS_IDX_ZQ_ACT 6'h33
`define DMS_IDX_SR_ACK 6'h34
`define DMS_IDX_PS_ACK 6'h35
`define DMS_IDX_MODE_SETUP 6'h37

// ****************************************************************
// Field positions
// ****************************************************************
`define DMS_FAW_MSB 7
`define DMS_COL_LSB 0
`define DMS_ROW_LSB 5
`define DMS_BANK_LSB 10
`define DMS_BG_LSB 14
`define DMS_CS_LSB 16
`define DMS_KIND_LSB 0
`define DMS_TGT_LSB 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define DMS_RST_KIND 3'h0
`define DMS_RST_TGT 4'hF
`define DMS_KIND_MRS 3'h0
`define DMS_KIND_MRR 3'h1
`define DMS_KIND_MPR 3'h2

`endif

// ===== rtl/dms_pkg.sv
/*
 Types for the DRAM maintenance register bank.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dms_pkg;

  // Mode register command sequencer, Gray along idle-issue-wait
  typedef enum logic [1:0] {
    DMS_IDLE = 2'b00,
    DMS_ISSUE = 2'b01,
    DMS_WAIT = 2'b11
  } dms_mode_state_t;

endpackage

// ===== rtl/dms_regs.sv
/*
 DRAM maintenance and configuration register bank: Avalon-MM slave with
 waitrequest, request bits toward the controller, progress flags back.
 Assumes controller-side inputs are on sys_clk_i; issue/done inputs are
 one-cycle pulses and only arrive for operations that were requested.
*/
// Added by the designer: the Avalon-MM slave port.
`include "dms_cfg.svh"

module dms_regs (
  input wire logic sys_clk_i, // Controller clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic [7:0] four_act_window_value_i, // Four-activate window
  input wire logic [4:0] col_addr_width_i, // Column address bits
  input wire logic [4:0] row_addr_width_i, // Row address bits
  input wire logic [3:0] bank_addr_width_i, // Bank address bits
  input wire logic [1:0] bg_addr_width_i, // Bank group bits
  input wire logic [2:0] cs_addr_width_i, // Chip select bits
  input wire logic [7:0] refresh_to_valid_time_i, // Refresh time, cycles
  input wire logic [15:0] zq_long_period_i, // Long ZQ period, cycles
  input wire logic [15:0] zq_short_period_i, // Short ZQ period, cycles
  output logic mode_command_go_o, // Mode command launch pulse
  output logic [2:0] mode_command_kind_o, // Mode command kind
  output logic [3:0] mode_command_targets_o, // Chip select targets
  input wire logic mode_command_done_i, // Mode command completed pulse
  output logic [3:0] refresh_req_o, // Per-rank refresh request
  input wire logic [3:0] refresh_issued_i, // Refresh sent to PHY pulses
  output logic zq_long_req_o, // Long ZQ request
  input wire logic zq_long_issued_i, // Long ZQ sent pulse
  output logic zq_short_req_o, // Short ZQ request
  input wire logic zq_short_issued_i, // Short ZQ sent pulse
  output logic [3:0] self_refresh_req_o, // Self-refresh request
  input wire logic self_refresh_active_i, // Memory in self-refresh
  output logic power_save_req_o, // Deep power saving request
  input wire logic power_save_active_i // Memory in power saving
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [5:0] idx;
  logic wr_en;
  logic [31:0] wdata;

  assign idx = avs_address_i[7:2];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_en = avs_write_i & ack_q;
  assign avs_readdata_o = rdata_q;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_be
      assign wdata[8*b +: 8] = avs_byteenable_i[b] ? avs_writedata_i[8*b +: 8] : 8'h00;
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic mode_req_q;
  logic [3:0] rfsh_q;
  logic zql_q;
  logic zqs_q;
  logic [3:0] sr_q;
  logic ps_q;
  logic [2:0] kind_q;
  logic [3:0] tgt_q;
  logic wr_mode;
  logic wr_rfsh;
  logic wr_zql;
  logic wr_zqs;

  assign wr_mode = wr_en & (idx == `DMS_IDX_MODE_REQ);
  assign wr_rfsh = wr_en & (idx == `DMS_IDX_RFSH_REQ);
  assign wr_zql = wr_en & (idx == `DMS_IDX_ZQL_REQ);
  assign wr_zqs = wr_en & (idx == `DMS_IDX_ZQS_REQ);

  dms_pkg::dms_mode_state_t state_q;

  // Set by software wins over the clear on completion
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_req_q <= 1'b0;
    end else if (wr_mode) begin
      mode_req_q <= wdata[0];
    end else if (mode_command_done_i && state_q == dms_pkg::DMS_WAIT) begin
      mode_req_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rfsh_q <= 4'h0;
    end else if (wr_rfsh) begin
      rfsh_q <= wdata[3:0] | (rfsh_q & ~refresh_issued_i);
    end else begin
      rfsh_q <= rfsh_q & ~refresh_issued_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      zql_q <= 1'b0;
    end else if (wr_zql) begin
      zql_q <= wdata[0];
    end else if (zq_long_issued_i) begin
      zql_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      zqs_q <= 1'b0;
    end else if (wr_zqs) begin
      zqs_q <= wdata[0];
    end else if (zq_short_issued_i) begin
      zqs_q <= 1'b0;
    end
  end

  // Held bits: only software changes them
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sr_q <= 4'h0;
      ps_q <= 1'b0;
      kind_q <= `DMS_RST_KIND;
      tgt_q <= `DMS_RST_TGT;
    end else if (wr_en) begin
      if (idx == `DMS_IDX_SR_REQ) begin
        sr_q <= wdata[3:0];
      end
      if (idx == `DMS_IDX_PS_REQ) begin
        ps_q <= wdata[0];
      end
      if (idx == `DMS_IDX_MODE_SETUP) begin
        kind_q <= wdata[`DMS_KIND_LSB +: 3];
        tgt_q <= wdata[`DMS_TGT_LSB +: 4];
      end
    end
  end

  assign refresh_req_o = rfsh_q;
  assign zq_long_req_o = zql_q;
  assign zq_short_req_o = zqs_q;
  assign self_refresh_req_o = sr_q;
  assign power_save_req_o = ps_q;
  assign mode_command_kind_o = kind_q;
  assign mode_command_targets_o = tgt_q;

  // ****************************************************************
  // Mode register command sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= dms_pkg::DMS_IDLE;
    end else begin
      unique case (state_q)
        dms_pkg::DMS_IDLE: begin
          if (mode_req_q) begin
            state_q <= dms_pkg::DMS_ISSUE;
          end
        end
        dms_pkg::DMS_ISSUE: begin
          state_q <= dms_pkg::DMS_WAIT;
        end
        dms_pkg::DMS_WAIT: begin
          if (mode_command_done_i) begin
            state_q <= dms_pkg::DMS_IDLE;
          end
        end
        default: begin
          state_q <= dms_pkg::DMS_IDLE;
        end
      endcase
    end
  end

  logic mode_active;
  assign mode_command_go_o = (state_q == dms_pkg::DMS_ISSUE);
  assign mode_active = (state_q != dms_pkg::DMS_IDLE);

  // ****************************************************************
  // Progress timers and self-refresh/power-save acknowledge flags
  // ****************************************************************
  logic rf_busy_q;
  logic [7:0] rf_cnt_q;
  logic zq_busy_q;
  logic [15:0] zq_cnt_q;
  logic sr_ack_q;
  logic ps_ack_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rf_busy_q <= 1'b0;
      rf_cnt_q <= 8'h00;
    end else if (|refresh_issued_i) begin
      rf_busy_q <= 1'b1;
      rf_cnt_q <= refresh_to_valid_time_i;
    end else if (rf_busy_q) begin
      if (rf_cnt_q <= 8'h01) begin
        rf_busy_q <= 1'b0;
      end else begin
        rf_cnt_q <= rf_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      zq_busy_q <= 1'b0;
      zq_cnt_q <= 16'h0000;
    end else if (zq_long_issued_i) begin
      zq_busy_q <= 1'b1;
      zq_cnt_q <= zq_long_period_i;
    end else if (zq_short_issued_i) begin
      zq_busy_q <= 1'b1;
      zq_cnt_q <= zq_short_period_i;
    end else if (zq_busy_q) begin
      if (zq_cnt_q <= 16'h0001) begin
        zq_busy_q <= 1'b0;
      end else begin
        zq_cnt_q <= zq_cnt_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sr_ack_q <= 1'b0;
      ps_ack_q <= 1'b0;
    end else begin
      sr_ack_q <= self_refresh_active_i;
      ps_ack_q <= power_save_active_i & ps_q;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      `DMS_IDX_FAW: rdata_d[`DMS_FAW_MSB:0] = four_act_window_value_i;
      `DMS_IDX_GEOM: begin
        rdata_d[`DMS_COL_LSB +: 5] = col_addr_width_i;
        rdata_d[`DMS_ROW_LSB +: 5] = row_addr_width_i;
        rdata_d[`DMS_BANK_LSB +: 4] = bank_addr_width_i;
        rdata_d[`DMS_BG_LSB +: 2] = bg_addr_width_i;
        rdata_d[`DMS_CS_LSB +: 3] = cs_addr_width_i;
      end
      `DMS_IDX_MODE_REQ: rdata_d[0] = mode_req_q;
      `DMS_IDX_RFSH_REQ: rdata_d[3:0] = rfsh_q;
      `DMS_IDX_ZQL_REQ: rdata_d[0] = zql_q;
      `DMS_IDX_ZQS_REQ: rdata_d[0] = zqs_q;
      `DMS_IDX_SR_REQ: rdata_d[3:0] = sr_q;
      `DMS_IDX_PS_REQ: rdata_d[0] = ps_q;
      `DMS_IDX_MODE_ACT: rdata_d[0] = mode_active;
      `DMS_IDX_RFSH_ACT: rdata_d[0] = rf_busy_q;
      `DMS_IDX_ZQ_ACT: rdata_d[0] = zq_busy_q;
      `DMS_IDX_SR_ACK: rdata_d[0] = sr_ack_q;
      `DMS_IDX_PS_ACK: rdata_d[0] = ps_ack_q;
      `DMS_IDX_MODE_SETUP: begin
        rdata_d[`DMS_KIND_LSB +: 3] = kind_q;
        rdata_d[`DMS_TGT_LSB +: 4] = tgt_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_bus_wait_one: assert property (
    (avs_read_i || avs_write_i) && !ack_q |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  a_mode_go_once: assert property (
    mode_command_go_o |=> !mode_command_go_o && mode_active)
    else $error("mode go not a single pulse");
  a_mode_active_done: assert property (
    state_q == dms_pkg::DMS_WAIT && mode_command_done_i |=> !mode_active)
    else $error("mode progress flag stuck after done");
  a_mode_self_clear: assert property (
    state_q == dms_pkg::DMS_WAIT && mode_command_done_i && !wr_mode |=> !mode_req_q)
    else $error("mode request not cleared on done");
  a_rfsh_clear: assert property (
    !wr_rfsh && (|refresh_issued_i) |=> (rfsh_q & $past(refresh_issued_i)) == 4'h0)
    else $error("refresh bit not cleared on issue");
  a_zq_long_clear: assert property (
    zq_long_issued_i && !wr_zql |=> !zql_q && zq_busy_q)
    else $error("long calibration bit not cleared");
  a_zq_short_clear: assert property (
    zq_short_issued_i && !wr_zqs |=> !zqs_q && zq_busy_q)
    else $error("short calibration bit not cleared");
  a_sr_hold: assert property (
    !(wr_en && idx == `DMS_IDX_SR_REQ) |=> $stable(sr_q))
    else $error("self-refresh request changed without write");
  a_ps_ack_cause: assert property (
    $rose(ps_ack_q) |-> $past(power_save_active_i) && $past(ps_q))
    else $error("power-save ack without entry");
  a_rf_busy_time: assert property (
    ((|refresh_issued_i) && refresh_to_valid_time_i == 8'h03)
      ##1 (!(|refresh_issued_i))[*3]
      |-> rf_busy_q && $past(rf_busy_q) && $past(rf_busy_q, 2) ##1 !rf_busy_q)
    else $error("refresh flag length wrong");
  a_zq_busy_end: assert property (
    zq_busy_q && zq_cnt_q == 16'h0001 && !zq_long_issued_i && !zq_short_issued_i
      |=> !zq_busy_q)
    else $error("calibration flag outlasts period");
  a_sr_ack_track: assert property (
    self_refresh_active_i |=> sr_ack_q)
    else $error("self-refresh ack missing");

  c_mode_done: cover property (mode_command_go_o ##[1:20] mode_command_done_i);
  c_rfsh_run: cover property ($rose(rf_busy_q) ##[1:50] $fell(rf_busy_q));
  c_sr_entry: cover property (sr_q == 4'hF ##[1:20] sr_ack_q);
  c_ps_entry: cover property (ps_q ##[1:20] ps_ack_q);

endmodule

// ===== testbench/dms_regs_tb_top.sv
/*
 Self-checking bench for the DRAM maintenance register bank.
 Assumes rtl/dms_regs.sv and rtl/dms_cfg.svh; the bench plays both software
 and controller side, driving every input but the clock by non-blocking assignment.
*/
`include "dms_cfg.svh"

module dms_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [7:0] faw_i = 8'hA5;
  logic [4:0] col_i = 5'h0A;
  logic [4:0] row_i = 5'h10;
  logic [3:0] bank_i = 4'h3;
  logic [1:0] bg_i = 2'h2;
  logic [2:0] cs_i = 3'h5;
  logic [7:0] rtv_i = 8'h28;
  logic [15:0] zql_i = 16'h001E;
  logic [15:0] zqs_i = 16'h0014;
  logic go_o;
  logic [2:0] kind_o;
  logic [3:0] tgt_o;
  logic done_i = 1'b0;
  logic [3:0] rfsh_o;
  logic [3:0] rfsh_iss_i = 4'h0;
  logic zql_o;
  logic zql_iss_i = 1'b0;
  logic zqs_o;
  logic zqs_iss_i = 1'b0;
  logic [3:0] sr_o;
  logic sr_act_i = 1'b0;
  logic ps_o;
  logic ps_act_i = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  dms_regs dms_regs_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .four_act_window_value_i(faw_i), .col_addr_width_i(col_i),
    .row_addr_width_i(row_i), .bank_addr_width_i(bank_i), .bg_addr_width_i(bg_i),
    .cs_addr_width_i(cs_i), .refresh_to_valid_time_i(rtv_i),
    .zq_long_period_i(zql_i), .zq_short_period_i(zqs_i),
    .mode_command_go_o(go_o), .mode_command_kind_o(kind_o),
    .mode_command_targets_o(tgt_o), .mode_command_done_i(done_i),
    .refresh_req_o(rfsh_o), .refresh_issued_i(rfsh_iss_i),
    .zq_long_req_o(zql_o), .zq_long_issued_i(zql_iss_i),
    .zq_short_req_o(zqs_o), .zq_short_issued_i(zqs_iss_i),
    .self_refresh_req_o(sr_o), .self_refresh_active_i(sr_act_i),
    .power_save_req_o(ps_o), .power_save_active_i(ps_act_i)
  );

  // ****************************************************************
  // Clock, watchdog, report
  // ****************************************************************
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // Avalon-MM master
  // ****************************************************************
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] dat);
    @(posedge sys_clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= wd;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    forever begin
      @(posedge sys_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    dat = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
    // Let the written register settle before outputs are compared
    @(posedge sys_clk_i);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_ro();
    rd_chk(`DMS_IDX_MODE_REQ, 32'h0);
    rd_chk(`DMS_IDX_RFSH_REQ, 32'h0);
    rd_chk(`DMS_IDX_SR_REQ, 32'h0);
    rd_chk(`DMS_IDX_MODE_SETUP, 32'h00000078);
    avs_byteenable_i <= 4'hE;
    wr_reg(`DMS_IDX_MODE_SETUP, 32'h0000007F);
    avs_byteenable_i <= 4'hF;
    rd_chk(`DMS_IDX_MODE_SETUP, 32'h0);
    wr_reg(`DMS_IDX_FAW, 32'hFFFFFFFF);
    rd_chk(`DMS_IDX_FAW, {24'h0, faw_i});
    wr_reg(`DMS_IDX_GEOM, 32'hFFFFFFFF);
    rd_chk(`DMS_IDX_GEOM, {13'h0, cs_i, bg_i, bank_i, row_i, col_i});
    wr_reg(6'h3F, 32'hFFFFFFFF);
    rd_chk(6'h3F, 32'h0);
  endtask

  task automatic t_mode();
    logic [3:0] tg[3] = '{4'hF, 4'h1, 4'h2};
    int i;
    for (int k = 0; k < 3; k++) begin
      wr_reg(`DMS_IDX_MODE_SETUP, {25'h0, tg[k], k[2:0]});
      chk({25'h0, tgt_o, kind_o}, {25'h0, tg[k], k[2:0]});
      wr_reg(`DMS_IDX_MODE_REQ, 32'h1);
      for (i = 0; i < 20; i++) begin
        @(posedge sys_clk_i);
        if (go_o === 1'b1) break;
      end
      chk({31'h0, go_o}, 32'h1);
      rd_chk(`DMS_IDX_MODE_REQ, 32'h1);
      rd_chk(`DMS_IDX_MODE_ACT, 32'h1);
      @(posedge sys_clk_i);
      done_i <= 1'b1;
      @(posedge sys_clk_i);
      done_i <= 1'b0;
      rd_chk(`DMS_IDX_MODE_REQ, 32'h0);
      rd_chk(`DMS_IDX_MODE_ACT, 32'h0);
    end
  endtask

  task automatic t_refresh();
    wr_reg(`DMS_IDX_RFSH_REQ, 32'hFFFFFFFA);
    rd_chk(`DMS_IDX_RFSH_REQ, 32'hA);
    chk({28'h0, rfsh_o}, 32'hA);
    @(posedge sys_clk_i);
    rfsh_iss_i <= 4'h2;
    @(posedge sys_clk_i);
    rfsh_iss_i <= 4'h0;
    rd_chk(`DMS_IDX_RFSH_REQ, 32'h8);
    rd_chk(`DMS_IDX_RFSH_ACT, 32'h1);
    tick(rtv_i + 5);
    rd_chk(`DMS_IDX_RFSH_ACT, 32'h0);
    @(posedge sys_clk_i);
    rfsh_iss_i <= 4'h8;
    rtv_i <= 8'h03;
    @(posedge sys_clk_i);
    rfsh_iss_i <= 4'h0;
    rd_chk(`DMS_IDX_RFSH_REQ, 32'h0);
    rd_chk(`DMS_IDX_RFSH_ACT, 32'h0);
  endtask

  task automatic t_zq(input logic lng);
    logic [5:0] idx;
    idx = lng ? `DMS_IDX_ZQL_REQ : `DMS_IDX_ZQS_REQ;
    wr_reg(idx, 32'h1);
    chk({30'h0, zql_o, zqs_o}, lng ? 32'h2 : 32'h1);
    @(posedge sys_clk_i);
    zql_iss_i <= lng;
    zqs_iss_i <= ~lng;
    @(posedge sys_clk_i);
    zql_iss_i <= 1'b0;
    zqs_iss_i <= 1'b0;
    rd_chk(idx, 32'h0);
    rd_chk(`DMS_IDX_ZQ_ACT, 32'h1);
    tick((lng ? zql_i : zqs_i) + 5);
    rd_chk(`DMS_IDX_ZQ_ACT, 32'h0);
  endtask

  task automatic t_sr_ps();
    wr_reg(`DMS_IDX_SR_REQ, 32'hF);
    chk({28'h0, sr_o}, 32'hF);
    rd_chk(`DMS_IDX_SR_ACK, 32'h0);
    sr_act_i <= 1'b1;
    tick(30);
    rd_chk(`DMS_IDX_SR_REQ, 32'hF);
    rd_chk(`DMS_IDX_SR_ACK, 32'h1);
    wr_reg(`DMS_IDX_SR_REQ, 32'h0);
    chk({28'h0, sr_o}, 32'h0);
    sr_act_i <= 1'b0;
    rd_chk(`DMS_IDX_SR_ACK, 32'h0);
    wr_reg(`DMS_IDX_PS_REQ, 32'h1);
    chk({31'h0, ps_o}, 32'h1);
    rd_chk(`DMS_IDX_PS_ACK, 32'h0);
    ps_act_i <= 1'b1;
    tick(30);
    rd_chk(`DMS_IDX_PS_ACK, 32'h1);
    chk({31'h0, ps_o}, 32'h1);
    wr_reg(`DMS_IDX_PS_REQ, 32'h0);
    chk({31'h0, ps_o}, 32'h0);
    rd_chk(`DMS_IDX_PS_ACK, 32'h0);
    ps_act_i <= 1'b0;
  endtask

  initial begin
    tick(8);
    rst_i <= 1'b0;
    t_reset_ro();
    t_mode();
    t_refresh();
    t_zq(1'b1);
    t_zq(1'b0);
    t_sr_ps();
    tick(4);
    wrap_up();
  end
endmodule
